// *** shared/pbcmux_pkg.sv ***
// Constants, register map and carrier types for the port B / port C pin mux.
// Assumes an APB slave with 32-bit data; every register occupies one word.
package pbcmux_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_B_ANSEL = 8'h00;
    localparam logic [7:0] ADDR_B_CHG = 8'h04;
    localparam logic [7:0] ADDR_B_LAT = 8'h08;
    localparam logic [7:0] ADDR_B_PIN = 8'h0C;
    localparam logic [7:0] ADDR_SLEW = 8'h10;
    localparam logic [7:0] ADDR_B_DIR = 8'h14;
    localparam logic [7:0] ADDR_B_PULL = 8'h18;
    localparam logic [7:0] ADDR_FUSES = 8'h1C;
    localparam logic [7:0] ADDR_C_DIR = 8'h20;
    localparam logic [7:0] ADDR_C_LAT = 8'h24;
    localparam logic [7:0] ADDR_C_ANSEL = 8'h28;
    localparam logic [7:0] ADDR_C_PIN = 8'h2C;
    localparam logic [7:0] ADDR_B_CHG_STAT = 8'h30;

    // ------------------------------------------------------------
    // Fuse bit positions and reset values
    // ------------------------------------------------------------
    localparam int FUSE_CAPTURE_COMPARE_2_BIT = 0;
    localparam int FUSE_T3C_BIT = 4;
    localparam int FUSE_SDO_BIT = 6;
    localparam logic [7:0] FUSE_WMASK = 8'h51;
    localparam logic [7:0] RST_FUSES = 8'h51;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_B_ANSEL = 8'h3F;
    localparam logic [7:0] RST_C_ANSEL = 8'hC4;
    localparam logic [7:0] B_ANSEL_MASK = 8'h3F;
    localparam logic [7:0] C_ANSEL_MASK = 8'hC4;
    localparam logic [7:0] C_IMPL_MASK = 8'hC7;
    localparam logic [7:0] B_CHG_MASK = 8'hF0;
    localparam logic [7:0] SLEW_MASK = 8'h1F;

    // ------------------------------------------------------------
    // Carriers to and from the peripherals
    // ------------------------------------------------------------
    typedef struct packed {
        logic sdo_oe;      // SPI data out enabled
        logic sdo;
        logic sck_out;     // Serial clock as master
        logic sck_oe;
        logic sda_oe;      // I2C data pulls low when set
        logic capture_compare_2_oe;     // Compare/PWM mode
        logic capture_compare_2;
        logic [2:0] pwm_oe; // Enhanced PWM outs 2..4
        logic [2:0] pwm;
    } pbcmux_periph_t;

    typedef struct packed {
        logic usart_dir_ovr;    // Forces C6/C7 direction
        logic usart_tx_oe;
        logic usart_tx;
        logic usart_dt_oe;
        logic usart_dt;
        logic dbg_data_oe;
        logic dbg_data;
    } pbcmux_serial_t;

    typedef struct packed {
        logic ext_ext_interrupt_0;
        logic pwm_fault;
        logic sr_latch_in;
        logic sda_in;
        logic sdi;
        logic sck_in;
        logic ext_ext_interrupt_2;
        logic charge_time_edge_1;
        logic charge_time_edge_2;
        logic capture_compare_2_capture;
        logic timer1_gate;
        logic timer3_ext_clock_in;
        logic dbg_clock;
        logic dbg_data_in;
        logic usart_rx;
    } pbcmux_inputs_t;

endpackage : pbcmux_pkg

// *** hw/pbcmux_top.sv ***
// Pin function mux for ports B and C with an APB register file.
// Assumes pins arrive asynchronous and peripheral signals on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pbcmux_top #(
    parameter bit SMALL_PACKAGE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pbcmux_pkg::pbcmux_periph_t periph,
    input wire pbcmux_pkg::pbcmux_serial_t serial,
    output pbcmux_pkg::pbcmux_inputs_t to_periph,
    output logic [7:0] b_analog_en,
    output logic [7:0] c_analog_en,
    output logic [3:0] b_change_pending,
    output logic [7:0] b_pullup_on,
    output logic [4:0] slew_limit,
    input wire logic [7:0] pin_b_in,
    output logic [7:0] pin_b_out,
    output logic [7:0] pin_b_oe,
    input wire logic [7:0] pin_c_in,
    output logic [7:0] pin_c_out,
    output logic [7:0] pin_c_oe
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] b_ansel_q, b_chg_q, b_lat_q, slew_q, b_dir_q, b_pull_q;
    logic [7:0] fuses_q, fuse_live_q, c_dir_q, c_lat_q, c_ansel_q;
    logic [7:0] b_sync1_q, b_sync2_q, c_sync1_q, c_sync2_q;
    logic [7:0] b_last_q;
    logic fuse_lock_q;
    logic wr_en, rd_en;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    function automatic logic addr_known(input logic [7:0] a);
        unique case (a)
            pbcmux_pkg::ADDR_B_ANSEL, pbcmux_pkg::ADDR_B_CHG, pbcmux_pkg::ADDR_B_LAT,
            pbcmux_pkg::ADDR_B_PIN, pbcmux_pkg::ADDR_SLEW, pbcmux_pkg::ADDR_B_DIR,
            pbcmux_pkg::ADDR_B_PULL, pbcmux_pkg::ADDR_FUSES, pbcmux_pkg::ADDR_C_DIR,
            pbcmux_pkg::ADDR_C_LAT, pbcmux_pkg::ADDR_C_ANSEL, pbcmux_pkg::ADDR_C_PIN,
            pbcmux_pkg::ADDR_B_CHG_STAT: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction : addr_known

    assign pslverr = psel && penable && !addr_known(paddr);

    function automatic logic hit(input logic [7:0] a);
        hit = wr_en && (paddr == a);
    endfunction : hit

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            b_sync1_q <= 8'h00;
            b_sync2_q <= 8'h00;
            c_sync1_q <= 8'h00;
            c_sync2_q <= 8'h00;
        end else begin
            b_sync1_q <= pin_b_in;
            b_sync2_q <= b_sync1_q;
            c_sync1_q <= pin_c_in;
            c_sync2_q <= c_sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Port B configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            b_ansel_q <= pbcmux_pkg::RST_B_ANSEL;
            b_chg_q <= 8'h00;
            b_lat_q <= 8'h00;
            slew_q <= 8'h00;
            b_dir_q <= pbcmux_pkg::RST_DIR;
            b_pull_q <= 8'h00;
        end else begin
            if (hit(pbcmux_pkg::ADDR_B_ANSEL)) begin
                b_ansel_q <= pwdata[7:0] & pbcmux_pkg::B_ANSEL_MASK;
            end
            if (hit(pbcmux_pkg::ADDR_B_CHG)) begin
                b_chg_q <= pwdata[7:0] & pbcmux_pkg::B_CHG_MASK;
            end
            // Writing the pin register lands in the latch
            if (hit(pbcmux_pkg::ADDR_B_LAT) || hit(pbcmux_pkg::ADDR_B_PIN)) begin
                b_lat_q <= pwdata[7:0];
            end
            if (hit(pbcmux_pkg::ADDR_SLEW)) begin
                slew_q <= pwdata[7:0] & pbcmux_pkg::SLEW_MASK;
            end
            if (hit(pbcmux_pkg::ADDR_B_DIR)) begin
                b_dir_q <= pwdata[7:0];
            end
            if (hit(pbcmux_pkg::ADDR_B_PULL)) begin
                b_pull_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Port C configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // Unimplemented port C bits read 0 even straight after reset
            c_dir_q <= pbcmux_pkg::RST_DIR & pbcmux_pkg::C_IMPL_MASK;
            c_lat_q <= 8'h00;
            c_ansel_q <= pbcmux_pkg::RST_C_ANSEL;
        end else begin
            if (hit(pbcmux_pkg::ADDR_C_DIR)) begin
                c_dir_q <= pwdata[7:0] & pbcmux_pkg::C_IMPL_MASK;
            end
            if (hit(pbcmux_pkg::ADDR_C_LAT) || hit(pbcmux_pkg::ADDR_C_PIN)) begin
                c_lat_q <= pwdata[7:0] & pbcmux_pkg::C_IMPL_MASK;
            end
            if (hit(pbcmux_pkg::ADDR_C_ANSEL)) begin
                c_ansel_q <= pwdata[7:0] & pbcmux_pkg::C_ANSEL_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Relocation fuses
    // ------------------------------------------------------------
    // Fuses are writable once after reset, then frozen; the mux reads the
    // live copy only, which is loaded on the same edge as the fuse register.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fuses_q <= pbcmux_pkg::RST_FUSES;
            fuse_live_q <= pbcmux_pkg::RST_FUSES;
            fuse_lock_q <= 1'b0;
        end else begin
            if (hit(pbcmux_pkg::ADDR_FUSES) && !fuse_lock_q) begin
                fuses_q <= pwdata[7:0] & pbcmux_pkg::FUSE_WMASK;
                fuse_live_q <= pwdata[7:0] & pbcmux_pkg::FUSE_WMASK;
                fuse_lock_q <= 1'b1;
            end
        end
    end

    logic sdo_on_b, t3_on_b, capture_compare_2_on_b;
    assign sdo_on_b = fuse_live_q[pbcmux_pkg::FUSE_SDO_BIT];
    assign t3_on_b = !fuse_live_q[pbcmux_pkg::FUSE_T3C_BIT];
    assign capture_compare_2_on_b = !fuse_live_q[pbcmux_pkg::FUSE_CAPTURE_COMPARE_2_BIT];

    // ------------------------------------------------------------
    // Digital input paths
    // ------------------------------------------------------------
    logic [7:0] b_din, c_din;
    assign b_din = b_sync2_q & ~b_ansel_q;
    assign c_din = c_sync2_q & ~c_ansel_q & pbcmux_pkg::C_IMPL_MASK;

    always_comb begin
        to_periph = '0;
        to_periph.ext_ext_interrupt_0 = b_din[0];
        to_periph.pwm_fault = b_din[0];
        to_periph.sr_latch_in = b_din[0];
        to_periph.sda_in = b_din[0];
        to_periph.sdi = b_din[0];
        to_periph.sck_in = b_din[1];
        to_periph.ext_ext_interrupt_2 = b_din[2];
        to_periph.charge_time_edge_1 = b_din[2];
        to_periph.charge_time_edge_2 = b_din[3];
        to_periph.capture_compare_2_capture = capture_compare_2_on_b ? b_din[3] : c_din[1];
        to_periph.timer1_gate = b_din[5];
        to_periph.timer3_ext_clock_in = t3_on_b ? b_din[5] : c_din[0];
        to_periph.dbg_clock = b_sync2_q[6];
        to_periph.dbg_data_in = b_sync2_q[7];
        to_periph.usart_rx = c_din[7];
    end

    // ------------------------------------------------------------
    // Port B output priority
    // ------------------------------------------------------------
    // Analog select is not consulted here: outputs drive analog pins too.
    logic [7:0] b_out_d, b_oe_d;
    always_comb begin
        b_out_d = b_lat_q;
        b_oe_d = ~b_dir_q;
        // Pin 0: I2C data is open drain, pulls low
        if (periph.sda_oe) begin
            b_out_d[0] = 1'b0;
            b_oe_d[0] = 1'b1;
        end
        // Pin 1: serial clock over PWM 3 over latch
        if (periph.sck_oe && !b_dir_q[1]) begin
            b_out_d[1] = periph.sck_out;
        end else if (SMALL_PACKAGE && periph.pwm_oe[1] && !b_dir_q[1]) begin
            b_out_d[1] = periph.pwm[1];
        end
        if (SMALL_PACKAGE && periph.pwm_oe[0] && !b_dir_q[2]) begin
            b_out_d[2] = periph.pwm[0];
        end
        // Pin 3: data out over capcomp2 over latch
        if (sdo_on_b && periph.sdo_oe && !b_dir_q[3]) begin
            b_out_d[3] = periph.sdo;
        end else if (capture_compare_2_on_b && periph.capture_compare_2_oe && !b_dir_q[3]) begin
            b_out_d[3] = periph.capture_compare_2;
        end
        if (SMALL_PACKAGE && periph.pwm_oe[2] && !b_dir_q[4]) begin
            b_out_d[4] = periph.pwm[2];
        end
        // Debug data on B7 ignores its direction bit; B6 follows its direction bit
        b_out_d[6] = b_lat_q[6];
        b_oe_d[6] = !b_dir_q[6];
        if (serial.dbg_data_oe) begin
            b_out_d[7] = serial.dbg_data;
            b_oe_d[7] = 1'b1;
        end else begin
            b_oe_d[7] = !b_dir_q[7];
        end
    end

    // ------------------------------------------------------------
    // Port C direction overrides and priority
    // ------------------------------------------------------------
    logic [7:0] c_out_d, c_oe_d, c_dir_eff;
    always_comb begin
        c_dir_eff = c_dir_q;
        if (serial.usart_dir_ovr) begin
            c_dir_eff[6] = !(serial.usart_tx_oe || serial.usart_dt_oe);
            c_dir_eff[7] = !serial.usart_dt_oe;
        end
        if (!sdo_on_b && periph.sdo_oe) begin
            c_dir_eff[7] = 1'b0;
        end
        c_out_d = c_lat_q;
        c_oe_d = ~c_dir_eff & pbcmux_pkg::C_IMPL_MASK;
        if (!capture_compare_2_on_b && periph.capture_compare_2_oe && !c_dir_q[1]) begin
            c_out_d[1] = periph.capture_compare_2;
        end
        if (serial.usart_dir_ovr && serial.usart_tx_oe) begin
            c_out_d[6] = serial.usart_tx;
        end else if (serial.usart_dir_ovr && serial.usart_dt_oe) begin
            c_out_d[6] = serial.usart_dt;
        end
        if (!sdo_on_b && periph.sdo_oe) begin
            c_out_d[7] = periph.sdo;
        end else if (serial.usart_dir_ovr && serial.usart_dt_oe) begin
            c_out_d[7] = serial.usart_dt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_b_out <= 8'h00;
            pin_b_oe <= 8'h00;
            pin_c_out <= 8'h00;
            pin_c_oe <= 8'h00;
        end else begin
            pin_b_out <= b_out_d;
            pin_b_oe <= b_oe_d;
            pin_c_out <= c_out_d;
            pin_c_oe <= c_oe_d;
        end
    end

    // ------------------------------------------------------------
    // Change detection on B4..B7
    // ------------------------------------------------------------
    // Only inputs with their enable set take part; a read of the pin
    // register refreshes the reference value.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            b_last_q <= 8'h00;
        end else if (rd_en && paddr == pbcmux_pkg::ADDR_B_PIN) begin
            b_last_q <= b_din;
        end
    end

    logic [7:0] b_mismatch;
    assign b_mismatch = (b_din ^ b_last_q) & b_chg_q & b_dir_q;
    assign b_change_pending = b_mismatch[7:4];

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                pbcmux_pkg::ADDR_B_ANSEL: prdata <= {24'h000000, b_ansel_q};
                pbcmux_pkg::ADDR_B_CHG: prdata <= {24'h000000, b_chg_q};
                pbcmux_pkg::ADDR_B_LAT: prdata <= {24'h000000, b_lat_q};
                pbcmux_pkg::ADDR_B_PIN: prdata <= {24'h000000, b_din};
                pbcmux_pkg::ADDR_SLEW: prdata <= {24'h000000, slew_q};
                pbcmux_pkg::ADDR_B_DIR: prdata <= {24'h000000, b_dir_q};
                pbcmux_pkg::ADDR_B_PULL: prdata <= {24'h000000, b_pull_q};
                pbcmux_pkg::ADDR_FUSES: prdata <= {24'h000000, fuses_q};
                pbcmux_pkg::ADDR_C_DIR: prdata <= {24'h000000, c_dir_q};
                pbcmux_pkg::ADDR_C_LAT: prdata <= {24'h000000, c_lat_q};
                pbcmux_pkg::ADDR_C_ANSEL: prdata <= {24'h000000, c_ansel_q};
                pbcmux_pkg::ADDR_C_PIN: prdata <= {24'h000000, c_din};
                pbcmux_pkg::ADDR_B_CHG_STAT: prdata <= {28'h0000000, b_change_pending};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign b_analog_en = b_ansel_q;
    assign c_analog_en = c_ansel_q;
    assign b_pullup_on = b_pull_q & b_dir_q;
    assign slew_limit = slew_q[4:0];

endmodule : pbcmux_top

`default_nettype wire

// *** verification/pbcmux_assertions.sv ***
// Concurrent checks on the port B/C pin mux, watching top-level ports only.
// Assumes pins reach the block through the board model and a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module pbcmux_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire pbcmux_pkg::pbcmux_periph_t periph,
    input wire pbcmux_pkg::pbcmux_serial_t serial,
    input wire pbcmux_pkg::pbcmux_inputs_t to_periph,
    input wire logic [7:0] b_analog_en,
    input wire logic [7:0] c_analog_en,
    input wire logic [7:0] pin_b_in,
    input wire logic [7:0] pin_b_out,
    input wire logic [7:0] pin_b_oe,
    input wire logic [7:0] pin_c_out,
    input wire logic [7:0] pin_c_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Register write steps and pin checks
    // ------------------------------------------------------------
    sequence wr_s(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    reset_analog_a: assert property (
        $fell(rst) |-> c_analog_en == 8'hC4 && pin_c_oe == 8'h00)
        else $error("port C not analog after reset");
    c_dir_drive_a: assert property (
        wr_s(pbcmux_pkg::ADDR_C_DIR) |-> ##2 pin_c_oe[1:0] == ~$past(pwdata[1:0], 2))
        else $error("port C driver does not follow direction");
    c_latch_out_a: assert property (
        wr_s(pbcmux_pkg::ADDR_C_LAT) ##2 pin_c_oe[0] |-> pin_c_out[0] == $past(pwdata[0], 2))
        else $error("port C pin does not show latch");
    b_latch_out_a: assert property (
        wr_s(pbcmux_pkg::ADDR_B_LAT) ##2 pin_b_oe[5] |-> pin_b_out[5] == $past(pwdata[5], 2))
        else $error("port B pin does not show latch");
    ext_interrupt_0_follow_a: assert property (
        !$past(rst) && !$past(rst, 2) && !b_analog_en[0] && !$past(b_analog_en[0])
        |-> to_periph.ext_ext_interrupt_0 == $past(pin_b_in[0], 2)) else $error("interrupt 0 input wrong");
    analog_block_a: assert property (
        b_analog_en[0] && $past(b_analog_en[0]) |-> !to_periph.ext_ext_interrupt_0)
        else $error("digital input seen on analog pin");
    dbg_clock_a: assert property (
        !$past(rst) && !$past(rst, 2) |-> to_periph.dbg_clock == $past(pin_b_in[6], 2))
        else $error("debug clock not passed through");
    usart_force_a: assert property (
        !$past(rst) && $past(serial.usart_dir_ovr) && $past(serial.usart_tx_oe)
        |-> pin_c_oe[6] && pin_c_out[6] == $past(serial.usart_tx)) else $error("override lost");
    b1_priority_a: assert property (
        !$past(rst) && $past(periph.sck_oe) && pin_b_oe[1] |-> pin_b_out[1] == $past(periph.sck_out))
        else $error("serial clock lost priority on B1");
endmodule : pbcmux_assertions

bind pbcmux_top pbcmux_assertions u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .periph, .serial, .to_periph, .b_analog_en, .c_analog_en, .pin_b_in, .pin_b_out,
    .pin_b_oe, .pin_c_out, .pin_c_oe);
`default_nettype wire

// *** verification/pbcmux_board.sv ***
// Board side of the package pins: external sources and the debug programmer.
// Assumes the bench sets each source level and whether it drives.
`timescale 1ns/1ps
`default_nettype none
module pbcmux_board (
    input wire logic [7:0] pin_b_out,
    input wire logic [7:0] pin_b_oe,
    input wire logic [7:0] pin_c_out,
    input wire logic [7:0] pin_c_oe,
    input wire logic [7:0] ext_b_en,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_c_en,
    input wire logic [7:0] ext_c,
    output logic [7:0] pin_b_in,
    output logic [7:0] pin_c_in
);
    // A floating pin shows the inverse of the device level, so stale data never matches
    // The programmer drives the B6 clock only while the device does not drive B6
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_b_in[i] = pin_b_oe[i] ? pin_b_out[i] : (ext_b_en[i] ? ext_b[i] : ~pin_b_out[i]);
            pin_c_in[i] = pin_c_oe[i] ? pin_c_out[i] : (ext_c_en[i] ? ext_c[i] : ~pin_c_out[i]);
        end
    end
endmodule : pbcmux_board
`default_nettype wire

// *** verification/tb_port_b_c_pin_function_mux.sv ***
// Self-checking bench for the port B/C pin mux over APB.
// Assumes the board model resolves pins; pin outputs lag their cause by one cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_port_b_c_pin_function_mux;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pbcmux_pkg::pbcmux_periph_t periph;
    pbcmux_pkg::pbcmux_serial_t serial;
    pbcmux_pkg::pbcmux_inputs_t to_periph;
    logic [7:0] b_analog_en, c_analog_en, b_pullup_on, pin_b_in, pin_b_out, pin_b_oe;
    logic [7:0] pin_c_in, pin_c_out, pin_c_oe, ext_b, ext_c, ext_b_en, ext_c_en;
    logic [3:0] b_change_pending;
    logic [4:0] slew_limit;
    int n_mismatch, checks;

    pbcmux_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periph, .serial, .to_periph, .b_analog_en, .c_analog_en,
        .b_change_pending, .b_pullup_on, .slew_limit, .pin_b_in, .pin_b_out, .pin_b_oe,
        .pin_c_in, .pin_c_out, .pin_c_oe);
    pbcmux_board board (.pin_b_out, .pin_b_oe, .pin_c_out, .pin_c_oe, .ext_b_en, .ext_b,
        .ext_c_en, .ext_c, .pin_b_in, .pin_c_in);

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held from setup until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            n_mismatch++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd[7:0], exp);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic t_reset;
        rdchk(pbcmux_pkg::ADDR_C_ANSEL, 8'hC4);
        rdchk(pbcmux_pkg::ADDR_C_DIR, 8'hFF & pbcmux_pkg::C_IMPL_MASK);
        rdchk(pbcmux_pkg::ADDR_C_LAT, 8'h00);
        rdchk(pbcmux_pkg::ADDR_FUSES, 8'h51);
        rdchk(8'h3C, 8'h00);
        chk({7'h0, err}, 8'h01);
        chk(pin_c_oe, 8'h00);
        chk(c_analog_en, 8'hC4);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cport;
        apb(1'h1, pbcmux_pkg::ADDR_C_DIR, 32'hFC);
        apb(1'h1, pbcmux_pkg::ADDR_C_LAT, 32'h42);
        cyc(2);
        chk(pin_c_oe & 8'h07, 8'h03);
        chk(pin_c_out & 8'h03, 8'h02);
        rdchk(pbcmux_pkg::ADDR_C_LAT, 8'h42);
        @(posedge clk_sys);
        serial <= '{usart_dir_ovr: 1'h1, usart_tx_oe: 1'h1, usart_tx: 1'h1, default: '0};
        cyc(2);
        chk(pin_c_oe & pin_c_out & 8'h40, 8'h40);
        rdchk(pbcmux_pkg::ADDR_C_DIR, 8'hC4);
        @(posedge clk_sys);
        serial <= '0;
        $display("test port C done");
    endtask : t_cport

    task automatic t_bport;
        apb(1'h1, pbcmux_pkg::ADDR_B_DIR, 32'h00);
        apb(1'h1, pbcmux_pkg::ADDR_B_LAT, 32'hA5);
        cyc(2);
        chk(pin_b_oe, 8'hFF);
        chk(pin_b_out, 8'hA5);
        @(posedge clk_sys);
        periph <= '{sck_oe: 1'h1, sck_out: 1'h0, pwm_oe: 3'h7, pwm: 3'h6, default: '0};
        cyc(2);
        chk(pin_b_out, 8'hB1);
        @(posedge clk_sys);
        periph.sck_oe <= 1'h0;
        cyc(2);
        chk(pin_b_out, 8'hB3);
        @(posedge clk_sys);
        periph <= '0;
        $display("test port B done");
    endtask : t_bport

    task automatic t_inputs;
        apb(1'h1, pbcmux_pkg::ADDR_B_DIR, 32'hFF);
        apb(1'h1, pbcmux_pkg::ADDR_B_ANSEL, 32'h00);
        @(posedge clk_sys);
        ext_b <= 8'h65;
        cyc(3);
        chk({to_periph.ext_ext_interrupt_0, to_periph.pwm_fault, to_periph.sr_latch_in, to_periph.sda_in,
            to_periph.sdi, to_periph.ext_ext_interrupt_2, to_periph.charge_time_edge_1,
            to_periph.timer1_gate}, 8'hFF);
        chk({7'h0, to_periph.dbg_clock}, 8'h01);
        apb(1'h1, pbcmux_pkg::ADDR_B_ANSEL, 32'h01);
        @(posedge clk_sys);
        ext_b <= 8'h09;
        cyc(3);
        chk({to_periph.charge_time_edge_2, to_periph.ext_ext_interrupt_0, 6'h0}, 8'h80);
        $display("test inputs done");
    endtask : t_inputs

    task automatic t_fuse;
        // C0 must be an input before the timer3 clock can be seen there
        apb(1'h1, pbcmux_pkg::ADDR_C_DIR, 32'hFF);
        @(posedge clk_sys);
        ext_c <= 8'h01;
        ext_b <= 8'h00;
        cyc(3);
        chk({7'h0, to_periph.timer3_ext_clock_in}, 8'h01);
        apb(1'h1, pbcmux_pkg::ADDR_FUSES, 32'h00);
        cyc(3);
        chk({7'h0, to_periph.timer3_ext_clock_in}, 8'h00);
        @(posedge clk_sys);
        ext_b <= 8'h20;
        cyc(3);
        chk({7'h0, to_periph.timer3_ext_clock_in}, 8'h01);
        apb(1'h1, pbcmux_pkg::ADDR_C_DIR, 32'h7F);
        apb(1'h1, pbcmux_pkg::ADDR_B_DIR, 32'hF7);
        @(posedge clk_sys);
        periph <= '{sdo_oe: 1'h1, sdo: 1'h1, default: '0};
        cyc(2);
        chk(pin_c_oe & pin_c_out & 8'h80, 8'h80);
        chk(pin_b_out & 8'h08, 8'h00);
        @(posedge clk_sys);
        periph <= '{capture_compare_2_oe: 1'h1, capture_compare_2: 1'h1, default: '0};
        cyc(2);
        chk(pin_b_out & 8'h08, 8'h08);
        apb(1'h1, pbcmux_pkg::ADDR_FUSES, 32'h51);
        rdchk(pbcmux_pkg::ADDR_FUSES, 8'h00);
        $display("test fuses done");
    endtask : t_fuse

    task automatic t_misc;
        apb(1'h1, pbcmux_pkg::ADDR_B_CHG, 32'hFF);
        apb(1'h1, pbcmux_pkg::ADDR_B_PULL, 32'hFF);
        apb(1'h1, pbcmux_pkg::ADDR_SLEW, 32'hFF);
        rdchk(pbcmux_pkg::ADDR_B_PIN, 8'h28);
        chk(b_pullup_on, 8'hF7);
        chk({3'h0, slew_limit}, 8'h1F);
        @(posedge clk_sys);
        ext_b <= 8'h30;
        cyc(3);
        chk({4'h0, b_change_pending}, 8'h01);
        rdchk(pbcmux_pkg::ADDR_B_CHG_STAT, 8'h01);
        rdchk(pbcmux_pkg::ADDR_B_PIN, 8'h38);
        cyc(1);
        chk({4'h0, b_change_pending}, 8'h00);
        $display("test change detect done");
    endtask : t_misc

    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        periph = '0;
        serial = '0;
        ext_b = 8'h00;
        ext_c = 8'h00;
        ext_b_en = 8'hFF;
        ext_c_en = 8'hFF;
        n_mismatch = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        t_reset();
        t_cport();
        t_bport();
        t_inputs();
        t_fuse();
        t_misc();
        stop_test();
    end
endmodule : tb_port_b_c_pin_function_mux
`default_nettype wire
